// file: inc/bcc_map.vh
// constants for the branch, call and clear instruction executor
// assumes 16-bit program words and a 21-bit byte program counter
`ifndef BCC_MAP_VH
`define BCC_MAP_VH
`define BCC_BZ_OPC       8'he0
`define BCC_CALL_OPC     7'h76
`define BCC_CALL2_OPC    4'hf
`define BCC_CLR_OPC      7'h35
`define BCC_PC_STEP      21'h000002
`define BCC_CALL_RET     21'h000004
`define BCC_IDX_MAX      8'h5f
`define BCC_CLEAR_VAL    8'h00
`define BCC_ACCESS_HI    8'hf0
`define BCC_ACCESS_SPLIT 8'h80
`define BCC_Z_BIT        2
`define BCC_Q1           4'h1
`define BCC_Q2           4'h2
`define BCC_Q3           4'h4
`define BCC_Q4           4'h8
`endif

// file: src/bcc_exec.v
// executes branch-on-zero, two-word call and clear-register
// assumes one instruction word per four-phase cycle; q phase walks q1..q4
// Contract
// RQ1 - taken branch: pc = addr + 2 + 2n
// RQ2 - branch opcode e0 low byte offset
// RQ3 - branch one cycle, two when taken
// RQ4 - call reaches 20-bit word address space
// RQ5 - call pushes addr+4, loads pc<20:1>
// RQ6 - fast bit copies w, status, bank
// RQ7 - call two words, second cycle idle
// RQ8 - clear writes 00h, sets zero only
// RQ9 - clear opcode, bank bit picks bank
// RQ10 - indexed offset when a=0, ext, f<=5f
// RQ11 - pc bit 0 stays zero
`timescale 1ns/10ps
`default_nettype none
`include "bcc_map.vh"
module bcc_exec #(
    parameter PCW = 21
) (
    input  wire           clk_i,
    input  wire           rst_n_i,
    // instruction fetch side, word taken at the q4 edge
    input  wire [15:0]    instr_i,
    input  wire           instr_valid_i,
    // core registers, read as levels
    input  wire [7:0]     working_i,
    input  wire [7:0]     status_i,
    input  wire [3:0]     bank_select_register_i,
    input  wire           ext_set_i,
    input  wire [11:0]    fsr2_i,
    // program counter and return stack
    output reg  [PCW-1:0] pc_o,
    output reg  [PCW-1:0] top_of_stack_o,
    output reg            push_o,
    // data register file, pulses show one clock after their phase
    output reg  [11:0]    data_addr_o,
    output reg  [7:0]     data_wdata_o,
    output reg            data_rd_o,
    output reg            data_we_o,
    // status and sequencing
    output reg            zero_set_o,
    output reg            flush_o,
    output reg  [3:0]     phase_o,
    // shadow copies kept for fast calls
    output wire [7:0]     working_shadow_o,
    output wire [7:0]     status_shadow_o,
    output wire [3:0]     bank_select_shadow_o
);
    // idle waits for a word, exec runs it, nop and call are the
    // dead second cycles of a taken branch and of a call
    localparam S_IDLE = 4'b0001;
    localparam S_EXEC = 4'b0010;
    localparam S_NOP  = 4'b0100;
    localparam S_CALL = 4'b1000;

    reg [3:0]     state;
    reg [3:0]     next_state;
    reg [15:0]    ir;
    reg [PCW-1:0] iaddr;
    reg [7:0]     call_lo;
    reg           shadow_save;
    wire [7:0]    off = ir[7:0];

    wire is_bz   = (ir[15:8] == `BCC_BZ_OPC);
    wire is_call = (ir[15:9] == `BCC_CALL_OPC);
    wire is_clr  = (ir[15:9] == `BCC_CLR_OPC);
    wire zero    = status_i[`BCC_Z_BIT];

    // sign extend and double the offset, kept to pc width
    wire [PCW-1:0] br_off = {{(PCW-9){off[7]}}, off, 1'b0};

    // branch target: own address, plus two, plus the doubled offset
    wire [PCW-1:0] br_target = iaddr + `BCC_PC_STEP + br_off;

    // return address pushed by a call, two words past the call
    wire [PCW-1:0] ret_addr = iaddr + `BCC_CALL_RET;

    // second call word must carry its marker, else the pc is left alone
    wire call2_ok = (instr_i[15:12] == `BCC_CALL2_OPC);

    // call target: the 20-bit literal lands on pc bits 20:1
    wire [PCW-1:0] call_target = {instr_i[11:0], call_lo, 1'b0};

    // address of the register the clear instruction names
    reg [11:0] clr_addr;
    always @* begin
        clr_addr = {bank_select_register_i, ir[7:0]};
        if (!ir[8]) begin
            // RQ10 indexed literal offset
            if (ext_set_i && ir[7:0] <= `BCC_IDX_MAX) begin
                // the sum wraps inside the 12-bit data space
                clr_addr = fsr2_i + {4'h0, ir[7:0]};
            end else if (ir[7:0] < `BCC_ACCESS_SPLIT) begin
                // RQ9 access bank, low half
                clr_addr = {4'h0, ir[7:0]};
            end else begin
                // RQ9 access bank, upper page
                clr_addr = {4'hf, ir[7:0]};
            end
        end
    end

    // four-phase sequencer, q1 through q4
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_o <= `BCC_Q1;
        end else begin
            // ring rotation keeps exactly one phase bit set
            phase_o <= {phase_o[2:0], phase_o[3]};
        end
    end

    always @* begin
        next_state = state;
        case (state)
            S_IDLE: begin
                // a word is taken only at the q4 edge
                if (instr_valid_i && phase_o == `BCC_Q4) begin
                    next_state = S_EXEC;
                end
            end
            S_EXEC: begin
                if (phase_o == `BCC_Q4) begin
                    if (is_bz && zero) begin
                        // RQ3 taken branch adds idle
                        next_state = S_NOP;
                    end else if (is_call) begin
                        // RQ7 call waits second word
                        next_state = S_CALL;
                    end else if (!instr_valid_i) begin
                        next_state = S_IDLE;
                    end
                end
            end
            S_NOP: begin
                // RQ3 flushed slot; without a valid word the fetch bus
                // may still hold the branch, which must not run again
                if (phase_o == `BCC_Q4) begin
                    next_state = instr_valid_i ? S_EXEC : S_IDLE;
                end
            end
            S_CALL: begin
                // RQ7 second call cycle does nothing
                if (phase_o == `BCC_Q4) begin
                    next_state = instr_valid_i ? S_EXEC : S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state          <= S_IDLE;
            ir             <= 16'h0000;
            iaddr          <= {PCW{1'b0}};
            pc_o           <= {PCW{1'b0}};
            top_of_stack_o <= {PCW{1'b0}};
            push_o         <= 1'b0;
            data_addr_o    <= 12'h000;
            data_wdata_o   <= 8'h00;
            data_rd_o      <= 1'b0;
            data_we_o      <= 1'b0;
            zero_set_o     <= 1'b0;
            flush_o        <= 1'b0;
            call_lo        <= 8'h00;
            shadow_save    <= 1'b0;
        end else begin
            state       <= next_state;
            push_o      <= 1'b0;
            data_rd_o   <= 1'b0;
            data_we_o   <= 1'b0;
            zero_set_o  <= 1'b0;
            flush_o     <= 1'b0;
            shadow_save <= 1'b0;
            // latch the next word at the end of each cycle that enters exec; exec is only
            // entered with a valid word, so a stale word is never rerun
            if (phase_o == `BCC_Q4 && next_state == S_EXEC) begin
                ir    <= instr_i;
                iaddr <= pc_o;
                pc_o  <= pc_o + `BCC_PC_STEP;
            end
            if (state == S_EXEC) begin
                case (phase_o)
                    `BCC_Q2: begin
                        if (is_clr) begin
                            // RQ8 read in q2
                            data_addr_o <= clr_addr;
                            data_rd_o   <= 1'b1;
                        end
                    end
                    `BCC_Q3: begin
                        if (is_call) begin
                            // RQ5 push return address
                            top_of_stack_o <= ret_addr;
                            push_o         <= 1'b1;
                            // low literal kept for the q4 pc load
                            call_lo        <= ir[7:0];
                            // RQ6 fast bit saves shadows
                            shadow_save    <= ir[8];
                        end
                    end
                    `BCC_Q4: begin
                        // RQ1 RQ2 taken branch target
                        if (is_bz && zero) begin
                            pc_o    <= br_target;
                            flush_o <= 1'b1;
                        end
                        // RQ4 RQ5 RQ11 load pc<20:1>
                        if (is_call && call2_ok) begin
                            pc_o    <= call_target;
                            flush_o <= 1'b1;
                        end
                        // RQ8 write zero and set z
                        if (is_clr) begin
                            data_addr_o  <= clr_addr;
                            data_wdata_o <= `BCC_CLEAR_VAL;
                            data_we_o    <= 1'b1;
                            zero_set_o   <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    bcc_shadow #(
        .W(8)
    ) u_shadow (
        .clk_i                (clk_i),
        .rst_n_i              (rst_n_i),
        .save_i               (shadow_save),
        .working_i            (working_i),
        .status_i             (status_i),
        .bank_i               (bank_select_register_i),
        .working_shadow_o     (working_shadow_o),
        .status_shadow_o      (status_shadow_o),
        .bank_select_shadow_o (bank_select_shadow_o)
    );
endmodule // bcc_exec
`default_nettype wire

// file: src/bcc_shadow.v
// shadow copies of working, status and bank select registers
// assumes the caller raises save_i for one clock to capture
`timescale 1ns/10ps
`default_nettype none
module bcc_shadow #(
    parameter W = 8
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire         save_i,
    input  wire [W-1:0] working_i,
    input  wire [W-1:0] status_i,
    input  wire [3:0]   bank_i,
    output reg  [W-1:0] working_shadow_o,
    output reg  [W-1:0] status_shadow_o,
    output reg  [3:0]   bank_select_shadow_o
);
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            working_shadow_o     <= {W{1'b0}};
            status_shadow_o      <= {W{1'b0}};
            bank_select_shadow_o <= 4'h0;
        end else if (save_i) begin
            working_shadow_o     <= working_i;
            status_shadow_o      <= status_i;
            bank_select_shadow_o <= bank_i;
        end
    end
endmodule // bcc_shadow
`default_nettype wire

// file: tb/bcc_exec_asserts.sv
// timing checks on the executor ports
// assumes it is bound into bcc_exec
`timescale 1ns/10ps
`default_nettype none
module bcc_exec_chk #(
    parameter PCW = 21
) (
    input wire logic           clk_i,
    input wire logic           rst_n_i,
    input wire logic [PCW-1:0] pc_o,
    input wire logic           push_o,
    input wire logic           data_rd_o,
    input wire logic           data_we_o,
    input wire logic [7:0]     data_wdata_o,
    input wire logic           zero_set_o,
    input wire logic           flush_o,
    input wire logic [3:0]     phase_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_pc_even: assert property (pc_o[0] == 1'b0) else $error("pc odd");
    a_phase_ring: assert property (1'b1 |=> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])})
        else $error("phase skipped");
    // registered pulses show one phase after the phase that makes them
    a_read_q2: assert property (data_rd_o |-> phase_o == 4'h4) else $error("read off q2");
    a_write_q4: assert property (data_we_o |-> phase_o == 4'h1 && data_wdata_o == 8'h00)
        else $error("bad clear write");
    a_zero_with_write: assert property (zero_set_o == data_we_o) else $error("zero flag");
    a_read_then_write: assert property (data_rd_o |-> ##2 data_we_o) else $error("no write");
    a_flush_q4: assert property (flush_o |-> phase_o == 4'h1) else $error("pc write off q4");
    a_idle_after: assert property (flush_o |=> (!data_rd_o && !push_o && !flush_o) [*4])
        else $error("busy idle cycle");
    a_push_q3: assert property (push_o |-> phase_o == 4'h8) else $error("push off q3");
endmodule // bcc_exec_chk
bind bcc_exec bcc_exec_chk #(.PCW(PCW)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .pc_o(pc_o),
    .push_o(push_o), .data_rd_o(data_rd_o), .data_we_o(data_we_o), .data_wdata_o(data_wdata_o),
    .zero_set_o(zero_set_o), .flush_o(flush_o), .phase_o(phase_o));
`default_nettype wire

// file: tb/bcc_regfile.sv
// data register file model: keeps the last write
// assumes write strobes last one clock
`timescale 1ns/10ps
`default_nettype none
module bcc_regfile (
    input  wire logic        clk_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        we_i,
    output var  logic [11:0] last_addr_o = 12'hfff,
    output var  logic [7:0]  last_data_o = 8'ha5
);
    always @(posedge clk_i) begin
        if (we_i) begin
            last_addr_o <= addr_i;
            last_data_o <= wdata_i;
        end
    end
endmodule // bcc_regfile
`default_nettype wire

// file: tb/branch_call_clear_exec_bench.sv
// self-checking bench for bcc_exec
// assumes words are sampled at q4 while valid
`timescale 1ns/10ps
`default_nettype none
module branch_call_clear_exec_bench;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic        instr_valid_i = 1'b0;
    logic [7:0]  working_i = 8'h3c;
    logic [7:0]  status_i = 8'h04;
    logic [3:0]  bank_select_register_i = 4'h3;
    logic        ext_set_i = 1'b0;
    logic [11:0] fsr2_i = 12'h100;
    logic [20:0] p0, pc_c;
    wire  [20:0] pc_o, top_of_stack_o;
    wire  [11:0] data_addr_o, last_addr;
    wire  [7:0]  data_wdata_o, working_shadow_o, status_shadow_o, last_data;
    wire  [3:0]  phase_o, bank_select_shadow_o;
    wire         push_o, data_rd_o, data_we_o, zero_set_o, flush_o;
    int          n_fail = 0;
    int          n_tests = 0;
    // clear word, extended set, expected address
    logic [28:0] rows [6] = '{{16'h6a10, 1'b0, 12'h010}, {16'h6a90, 1'b0, 12'hf90},
        {16'h6b44, 1'b0, 12'h344}, {16'h6a5f, 1'b1, 12'h15f}, {16'h6a60, 1'b1, 12'h060},
        {16'h6b20, 1'b1, 12'h320}};
    bcc_exec dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .working_i(working_i), .status_i(status_i),
        .bank_select_register_i(bank_select_register_i), .ext_set_i(ext_set_i),
        .fsr2_i(fsr2_i), .pc_o(pc_o), .top_of_stack_o(top_of_stack_o), .push_o(push_o),
        .data_addr_o(data_addr_o), .data_wdata_o(data_wdata_o), .data_rd_o(data_rd_o),
        .data_we_o(data_we_o), .zero_set_o(zero_set_o), .flush_o(flush_o), .phase_o(phase_o),
        .working_shadow_o(working_shadow_o), .status_shadow_o(status_shadow_o),
        .bank_select_shadow_o(bank_select_shadow_o));
    bcc_regfile mem_u (.clk_i(clk_i), .addr_i(data_addr_o), .wdata_i(data_wdata_o),
        .we_i(data_we_o), .last_addr_o(last_addr), .last_data_o(last_data));
    always #20 clk_i = ~clk_i;
    task automatic chk(input logic ok);
        n_tests++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("BAD %0t check %0d", $time, n_tests);
        end
    endtask
    // present one word for the next q4 sample; p0 is the pc at that time
    task automatic put(input logic [15:0] w);
        do @(negedge clk_i); while (phase_o !== 4'h4);
        p0 = pc_o;
        @(posedge clk_i);
        instr_i <= w;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
    endtask
    // longest instruction costs eight clocks
    task automatic settle;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk_i);
            ext_set_i <= rows[i][12];
            put(rows[i][28:13]);
            settle;
            chk(last_addr === rows[i][11:0] && last_data === 8'h00);
        end
        // fast call to a literal with its top bit set
        put(16'hed45);
        pc_c = p0;
        put(16'hff23);
        settle;
        chk(pc_o === 21'h1e468a);
        chk(top_of_stack_o === pc_c + 21'h4);
        chk({working_shadow_o, status_shadow_o, bank_select_shadow_o} === 20'h3c043);
        // taken branches at offset -2 and the +127 extreme, then a branch not taken
        put(16'he0fe);
        pc_c = p0;
        settle;
        chk(pc_o === pc_c - 21'h2);
        put(16'he07f);
        pc_c = p0;
        settle;
        chk(pc_o === pc_c + 21'h100);
        @(posedge clk_i);
        status_i <= 8'h00;
        working_i <= 8'h99;
        bank_select_register_i <= 4'h7;
        put(16'he07f);
        pc_c = p0;
        settle;
        chk(pc_o === pc_c + 21'h2);
        // plain call leaves the shadows alone
        put(16'hec00);
        pc_c = p0;
        put(16'hf000);
        settle;
        chk(pc_o === 21'h0 && status_shadow_o === 8'h04 && working_shadow_o === 8'h3c);
        chk(bank_select_shadow_o === 4'h3 && top_of_stack_o === pc_c + 21'h4);
        report_and_stop;
    end
endmodule // branch_call_clear_exec_bench
`default_nettype wire
